// ---- rtl/dtc_timer.sv ----
/*
 Two 16-bit timer/counters with four modes behind an AHB-Lite slave.
 Assumes one 10 MHz clock, a synchronous active-low reset, and the rc
 clock and count inputs arriving asynchronously on pins.
*/
`timescale 1ns/100ps
`include "dtc_defines.svh"

module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [31:0]      HRDATA_O,
  input  wire logic        RC_CLK_I,
  input  wire logic        T0_CNT_I,
  input  wire logic        T1_CNT_I,
  output logic             TMR0_IRQ_O,
  output logic             TMR1_IRQ_O
);

  // bus slave
  dtc_aph_t   aph_q;
  logic [7:0] hrdata_q;
  logic [7:0] rd_val;
  logic [7:0] wdata;
  logic       rd_go;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_clk;
  logic       wr_ien;
  logic       wr_csel;
  logic [1:0] wr_lo;
  logic [1:0] wr_hi;

  // registers
  logic [7:0] ctrl_w;
  logic [1:0] run_q;
  logic       flag0_q;
  logic       flag1_q;
  logic [7:0] mode_q;
  logic [7:0] clk_q;
  logic [7:0] ien_q;
  logic [7:0] csel_q;
  logic [7:0] lo_q [2];
  logic [7:0] hi_q [2];

  // time base
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [2:0] edge_w;
  logic [3:0] pre_q;
  logic [2:0] rc_q;
  logic       pre_tick;
  logic       rc_tick;

  // counting
  dtc_mode_t  md [2];
  logic       split;
  logic [1:0] run;
  logic [1:0] tick;
  logic [1:0] ovf_lo;
  logic       ovf_hi0;
  logic       hi0_run;
  logic       set1;
  logic [1:0] src;
  logic [1:0] pre;
  logic [1:0] cst;

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = {24'h000000, hrdata_q};

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      aph_q <= '0;
    end else if (HREADY_I) begin
      aph_q.valid <= HSEL_I & HTRANS_I[1];
      aph_q.write <= HWRITE_I;
      aph_q.idx   <= HADDR_I[9:2];
    end
  end

  always_comb begin
    case (HADDR_I[9:2])
      `DTC_IDX_CTRL: rd_val = ctrl_w;
      `DTC_IDX_MODE: rd_val = mode_q;
      `DTC_IDX_LO0:  rd_val = lo_q[0];
      `DTC_IDX_HI0:  rd_val = hi_q[0];
      `DTC_IDX_LO1:  rd_val = lo_q[1];
      `DTC_IDX_HI1:  rd_val = hi_q[1];
      `DTC_IDX_CLK:  rd_val = clk_q;
      `DTC_IDX_IEN:  rd_val = ien_q;
      `DTC_IDX_CSEL: rd_val = csel_q;
      default:       rd_val = `DTC_RST_BYTE;
    endcase
  end

  // read data is taken with the address phase and stands one cycle later
  assign rd_go = HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      hrdata_q <= `DTC_RST_BYTE;
    end else if (rd_go) begin
      hrdata_q <= rd_val;
    end
  end

  wire wr_go = aph_q.valid & aph_q.write;
  assign wdata   = HWDATA_I[7:0];
  assign wr_ctrl = wr_go && (aph_q.idx == `DTC_IDX_CTRL);
  assign wr_mode = wr_go && (aph_q.idx == `DTC_IDX_MODE);
  assign wr_clk  = wr_go && (aph_q.idx == `DTC_IDX_CLK);
  assign wr_ien  = wr_go && (aph_q.idx == `DTC_IDX_IEN);
  assign wr_csel = wr_go && (aph_q.idx == `DTC_IDX_CSEL);
  assign wr_lo[0] = wr_go && (aph_q.idx == `DTC_IDX_LO0);
  assign wr_hi[0] = wr_go && (aph_q.idx == `DTC_IDX_HI0);
  assign wr_lo[1] = wr_go && (aph_q.idx == `DTC_IDX_LO1);
  assign wr_hi[1] = wr_go && (aph_q.idx == `DTC_IDX_HI1);

  // configuration registers; blank bits stay zero
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= `DTC_RST_BYTE;
    end else if (wr_mode) begin
      mode_q <= wdata & `DTC_MASK_MODE;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      clk_q <= `DTC_RST_BYTE;
    end else if (wr_clk) begin
      clk_q <= wdata & `DTC_MASK_CLK;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ien_q <= `DTC_RST_BYTE;
    end else if (wr_ien) begin
      ien_q <= wdata & `DTC_MASK_IEN;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      csel_q <= `DTC_RST_BYTE;
    end else if (wr_csel) begin
      csel_q <= wdata & `DTC_MASK_CSEL;
    end
  end

  // run bits follow software only
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      run_q <= 2'h0;
    end else if (wr_ctrl) begin
      run_q[0] <= wdata[`DTC_CTRL_TR0];
      run_q[1] <= wdata[`DTC_CTRL_TR1];
    end
  end

  // flag 0: a hardware set wins over a software clear
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      flag0_q <= 1'b0;
    end else if (ovf_lo[0]) begin
      flag0_q <= 1'b1;
    end else if (wr_ctrl) begin
      flag0_q <= wdata[`DTC_CTRL_TF0];
    end
  end

  // flag 1: set by the second timer, or by the split high byte
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      flag1_q <= 1'b0;
    end else if (set1) begin
      flag1_q <= 1'b1;
    end else if (wr_ctrl) begin
      flag1_q <= wdata[`DTC_CTRL_TF1];
    end
  end

  // control register image; blank bits read zero
  always_comb begin
    ctrl_w                = `DTC_RST_BYTE;
    ctrl_w[`DTC_CTRL_TF1] = flag1_q;
    ctrl_w[`DTC_CTRL_TR1] = run_q[1];
    ctrl_w[`DTC_CTRL_TF0] = flag0_q;
    ctrl_w[`DTC_CTRL_TR0] = run_q[0];
  end

  // requests gated by enables
  assign TMR0_IRQ_O = flag0_q & ien_q[`DTC_IEN_ET0];
  assign TMR1_IRQ_O = flag1_q & ien_q[`DTC_IEN_ET1];

  // pin synchronisers: rc clock, count input 0, count input 1
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      s1_q <= {T1_CNT_I, T0_CNT_I, RC_CLK_I};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  // rising edge once the two late stages agree
  assign edge_w = s2_q & s3_q & ~lvl_q;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pre_q <= `DTC_PRE_RST;
    end else if (pre_q == `DTC_PRE_LAST) begin
      pre_q <= `DTC_PRE_RST;
    end else begin
      pre_q <= pre_q + `DTC_ONE4;
    end
  end
  assign pre_tick = (pre_q == `DTC_PRE_LAST);

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rc_q <= `DTC_RC_RST;
    end else if (edge_w[0]) begin
      rc_q <= rc_q + `DTC_ONE3;
    end
  end
  assign rc_tick = edge_w[0] && (rc_q == `DTC_RC_LAST);

  assign md[0] = dtc_mode_t'(mode_q[`DTC_MODE0_LSB +: 2]);
  assign md[1] = dtc_mode_t'(mode_q[`DTC_MODE1_LSB +: 2]);
  assign split = (md[0] == DTC_MODESPLIT);
  assign src = {clk_q[`DTC_CLK_SRC1], clk_q[`DTC_CLK_SRC0]};
  assign pre = {clk_q[`DTC_CLK_PRE1], clk_q[`DTC_CLK_PRE0]};
  assign cst = {csel_q[`DTC_CSEL_CT1], csel_q[`DTC_CSEL_CT0]};

  assign run[0] = run_q[0];
  assign run[1] = split ? (md[1] != DTC_MODESPLIT)
                        : run_q[1];

  // split high byte runs under the second run bit, every clock
  assign hi0_run = split && run_q[1];
  assign ovf_hi0 = hi0_run && (hi_q[0] == `DTC_BYTE_MAX);
  assign set1    = split ? ovf_hi0 : ovf_lo[1];

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic        sysc;
    logic        forced;
    logic [7:0]  lo_n;
    logic [7:0]  hi_n;
    logic        ovf;
    logic [13:0] s13;
    logic [16:0] s16;

    // second timer under split counts the system clock only
    assign forced = (i == 1) && split;
    assign sysc = pre[i] ? 1'b1 : pre_tick;
    always_comb begin
      if (forced) begin
        tick[i] = 1'b1;
      end else if (cst[i]) begin
        tick[i] = edge_w[i+1];
      end else if (src[i]) begin
        tick[i] = rc_tick;
      end else begin
        tick[i] = sysc;
      end
    end

    assign s13 = {1'b0, hi_q[i], lo_q[i][4:0]} + `DTC_ONE14;
    assign s16 = {1'b0, hi_q[i], lo_q[i]} + `DTC_ONE17;

    always_comb begin
      lo_n = lo_q[i];
      hi_n = hi_q[i];
      ovf  = 1'b0;
      if (run[i] && tick[i]) begin
        case (md[i])
          DTC_MODE13: begin
            hi_n = s13[12:5];
            lo_n = {lo_q[i][7:5], s13[4:0]};
            ovf  = s13[13];
          end
          DTC_MODE16: begin
            {hi_n, lo_n} = s16[15:0];
            ovf = s16[16];
          end
          DTC_MODE8R: begin
            if (lo_q[i] == `DTC_BYTE_MAX) begin
              lo_n = hi_q[i];
              ovf  = 1'b1;
            end else begin
              lo_n = lo_q[i] + `DTC_ONE8;
            end
          end
          default: begin
            if (i == 0) begin
              lo_n = lo_q[i] + `DTC_ONE8;
              ovf  = (lo_q[i] == `DTC_BYTE_MAX);
            end
          end
        endcase
      end
      if (i == 0 && split) begin
        hi_n = hi_q[i];
        if (hi0_run) begin
          hi_n = hi_q[i] + `DTC_ONE8;
        end
      end
    end

    // second timer overflow is discarded while split
    assign ovf_lo[i] = ovf && !forced;

    // software writes take the byte over the count
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
        lo_q[i] <= `DTC_RST_BYTE;
        hi_q[i] <= `DTC_RST_BYTE;
      end else begin
        lo_q[i] <= wr_lo[i] ? wdata : lo_n;
        hi_q[i] <= wr_hi[i] ? wdata : hi_n;
      end
    end
  end

endmodule : dtc_timer

// ---- rtl/dtc_defines.svh ----
/*
 Register indices, field positions, reset values and divider counts
 for the dual timer/counter. Assumes inclusion by bare name.
*/
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// register indices; byte address is four times the index
`define DTC_IDX_CTRL   8'h88
`define DTC_IDX_MODE   8'h89
`define DTC_IDX_LO0    8'h8a
`define DTC_IDX_HI0    8'h8b
`define DTC_IDX_LO1    8'h8c
`define DTC_IDX_HI1    8'h8d
`define DTC_IDX_CLK    8'h8f
`define DTC_IDX_IEN    8'h90
`define DTC_IDX_CSEL   8'h91

// control register fields
`define DTC_CTRL_TF1   7
`define DTC_CTRL_TR1   6
`define DTC_CTRL_TF0   5
`define DTC_CTRL_TR0   4
// mode register field positions
`define DTC_MODE0_LSB  0
`define DTC_MODE1_LSB  4
// clock select register fields
`define DTC_CLK_SRC0   5
`define DTC_CLK_SRC1   6
`define DTC_CLK_PRE0   2
`define DTC_CLK_PRE1   3
// interrupt enable and counter select fields
`define DTC_IEN_ET0    0
`define DTC_IEN_ET1    1
`define DTC_CSEL_CT0   0
`define DTC_CSEL_CT1   1

// writable bit masks
`define DTC_MASK_CTRL  8'hf0
`define DTC_MASK_MODE  8'h33
`define DTC_MASK_CLK   8'h6c
`define DTC_MASK_IEN   8'h03
`define DTC_MASK_CSEL  8'h03

`define DTC_RST_BYTE   8'h00
`define DTC_BYTE_MAX   8'hff
`define DTC_ONE8       8'h01
`define DTC_ONE14      14'h0001
`define DTC_ONE17      17'h00001
`define DTC_ONE4       4'h1
`define DTC_ONE3       3'h1
// system clock divided by twelve: counts 0..11
`define DTC_PRE_LAST   4'hb
`define DTC_PRE_RST    4'h0
// rc clock divided by eight: counts 0..7
`define DTC_RC_LAST    3'h7
`define DTC_RC_RST     3'h0

`endif

// ---- rtl/dtc_pkg.sv ----
/*
 Types shared by the dual timer/counter.
 Assumes dtc_defines.svh is available for constants.
*/
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE13,
    DTC_MODE16,
    DTC_MODE8R,
    DTC_MODESPLIT
  } dtc_mode_t;

  // captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } dtc_aph_t;

endpackage : dtc_pkg

// ---- dv/dtc_timer_sva.sv ----
/*
 Port checks for dtc_timer: read data, interrupt enables, flag writes.
 Assumes a bind from the bench and the single system clock domain.
*/
`timescale 1ns/100ps
`include "dtc_defines.svh"
module dtc_timer_sva
  import dtc_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        TMR0_IRQ_O,
  input wire logic        TMR1_IRQ_O
);
  dtc_aph_t   ap_q;
  logic [1:0] en_q;
  logic       wr;
  logic       rd;

  assign wr = ap_q.valid && ap_q.write;
  assign rd = ap_q.valid && !ap_q.write;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) ap_q <= '0;
    else if (HREADY_I)
      ap_q <= {HSEL_I && HTRANS_I[1], HWRITE_I, HADDR_I[9:2]};
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) en_q <= 2'h0;
    else if (wr && ap_q.idx == `DTC_IDX_IEN) en_q <= HWDATA_I[1:0];
  end

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_ctrl_wr;
    wr && ap_q.idx == `DTC_IDX_CTRL;
  endsequence

  a_irq0_enable: assert property (TMR0_IRQ_O |-> en_q[0])
    else $error("irq0 while disabled");
  a_irq1_enable: assert property (TMR1_IRQ_O |-> en_q[1])
    else $error("irq1 while disabled");
  a_flag0_req: assert property (
    s_ctrl_wr ##0 (HWDATA_I[5] && en_q[0]) |=> TMR0_IRQ_O)
    else $error("flag0 write gave no irq");
  a_flag1_req: assert property (
    s_ctrl_wr ##0 (HWDATA_I[7] && en_q[1]) |=> TMR1_IRQ_O)
    else $error("flag1 write gave no irq");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RST_N_I |=> !TMR0_IRQ_O && !TMR1_IRQ_O)
    else $error("irq after reset");
  a_ctrl_blank: assert property (
    rd && ap_q.idx == `DTC_IDX_CTRL |-> HRDATA_O[3:0] == 4'h0)
    else $error("ctrl blank bits set");
  a_mode_blank: assert property (
    rd && ap_q.idx == `DTC_IDX_MODE
    |-> (HRDATA_O[7:0] & ~`DTC_MASK_MODE) == 8'h00)
    else $error("mode blank bits set");
  a_byte_wide: assert property (HRDATA_O[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule : dtc_timer_sva

// ---- dv/dtc_timer_test.sv ----
/*
 Self-checking bench for dtc_timer: registers, modes, clocks, split.
 Assumes the design and the checker are compiled ahead of it.
*/
`timescale 1ns/100ps
`include "dtc_defines.svh"
module dtc_timer_test;
  localparam logic [7:0] CT = `DTC_IDX_CTRL, MD = `DTC_IDX_MODE;
  localparam logic [7:0] L0 = `DTC_IDX_LO0, H0 = `DTC_IDX_HI0;
  localparam logic [7:0] L1 = `DTC_IDX_LO1, H1 = `DTC_IDX_HI1;
  localparam logic [7:0] CK = `DTC_IDX_CLK, IE = `DTC_IDX_IEN;
  localparam logic [7:0] CS = `DTC_IDX_CSEL;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, rck, t0, irq0, irq1;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  d, e;
  logic        hit, t1;
  int          mismatches, n_compared;

  dtc_timer u_dtc_timer (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .RC_CLK_I(rck), .T0_CNT_I(t0),
    .T1_CNT_I(t1), .TMR0_IRQ_O(irq0), .TMR1_IRQ_O(irq1));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rck = 1'b0;
    forever #3906 rck = ~rck;
  end

  task close_out;
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] g, x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, g, x);
    end
  endtask : chk

  task rdy;
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      i++;
      if (i > 50) begin
        mismatches++;
        $display("MISMATCH %0t bus hang", $time);
        close_out;
      end
      @(posedge clk);
    end
  endtask : rdy

  task xfer(input logic w, input logic [7:0] a, x);
    hsel <= 1'b1;
    haddr <= {22'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, x};
    rdy;
    d = hrdata[7:0];
  endtask : xfer

  task wr(input logic [7:0] a, x);
    xfer(1'b1, a, x);
  endtask : wr

  task rchk(input logic [7:0] a, x);
    xfer(1'b0, a, 8'h00);
    chk(d, x);
    chk({7'h0, hresp}, 8'h00);
  endtask : rchk

  task look(input int n, input logic s, x);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((s ? irq1 : irq0) === 1'b1) hit = 1'b1;
    end
    @(posedge clk);
    chk({7'h0, hit}, {7'h0, x});
  endtask : look

  task t_regs;
    logic [7:0] a [5];
    logic [7:0] m [5];
    a = '{MD, CK, IE, CS, 8'h8e};
    m = '{`DTC_MASK_MODE, `DTC_MASK_CLK, `DTC_MASK_IEN, `DTC_MASK_CSEL, 8'h0};
    for (int i = 0; i < 5; i++) begin
      rchk(a[i], 8'h00);
      wr(a[i], m[i]);
      rchk(a[i], m[i]);
      wr(a[i], 8'h00);
    end
    rchk(CT, 8'h00);
    wr(L0, 8'ha5);
    rchk(L0, 8'ha5);
    wr(IE, 8'h01);
    wr(CT, 8'ha0);
    rchk(CT, 8'ha0);
    look(1, 1'b0, 1'b1);
    look(1, 1'b1, 1'b0);
    wr(IE, 8'h03);
    look(1, 1'b1, 1'b1);
    wr(CT, 8'h00);
    look(1, 1'b0, 1'b0);
  endtask : t_regs

  task t_wrap(input logic [7:0] md, ck, hi, lo, input logic x,
              input logic [7:0] eh);
    wr(MD, md);
    wr(CK, ck);
    wr(H0, hi);
    wr(L0, lo);
    wr(IE, 8'h01);
    wr(CT, 8'h10);
    look(20, 1'b0, x);
    wr(CT, 8'h00);
    rchk(H0, eh);
    xfer(1'b0, L0, 8'h00);
    e = d;
    rchk(L0, e);
  endtask : t_wrap

  task t_ext;
    wr(CS, 8'h03);
    wr(MD, 8'h11);
    wr(H0, 8'hff);
    wr(L0, 8'hfe);
    wr(H1, 8'hff);
    wr(L1, 8'hfe);
    wr(IE, 8'h03);
    wr(CT, 8'h50);
    look(10, 1'b0, 1'b0);
    look(1, 1'b1, 1'b0);
    repeat (2) begin
      t0 <= 1'b1;
      t1 <= 1'b1;
      repeat (4) @(posedge clk);
      t0 <= 1'b0;
      t1 <= 1'b0;
      repeat (4) @(posedge clk);
    end
    look(10, 1'b0, 1'b1);
    look(1, 1'b1, 1'b1);
    wr(CT, 8'h00);
    wr(CS, 8'h00);
  endtask : t_ext

  task t_split;
    wr(H0, 8'h00);
    wr(L0, 8'h00);
    wr(H1, 8'hff);
    wr(L1, 8'h1c);
    wr(IE, 8'h03);
    wr(MD, 8'h03);
    wr(CT, 8'h40);
    look(20, 1'b1, 1'b0);
    rchk(H1, 8'h00);
    wr(H0, 8'hfc);
    look(20, 1'b1, 1'b1);
    look(1, 1'b0, 1'b0);
    wr(MD, 8'h33);
    xfer(1'b0, L1, 8'h00);
    e = d;
    rchk(L1, e);
    wr(CT, 8'h00);
  endtask : t_split

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    t0 = 1'b0;
    t1 = 1'b0;
    rst_n = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_wrap(8'h00, 8'h04, 8'hff, 8'h1c, 1'b1, 8'h00);
    t_wrap(8'h01, 8'h04, 8'hff, 8'h1c, 1'b0, 8'hff);
    t_wrap(8'h01, 8'h04, 8'hff, 8'hfc, 1'b1, 8'h00);
    t_wrap(8'h02, 8'h04, 8'hc0, 8'hfc, 1'b1, 8'hc0);
    t_wrap(8'h01, 8'h00, 8'hff, 8'hfc, 1'b0, 8'hff);
    t_wrap(8'h01, 8'h24, 8'hff, 8'hfc, 1'b0, 8'hff);
    t_ext;
    t_split;
    close_out;
  end
endmodule : dtc_timer_test

bind dtc_timer dtc_timer_sva u_dtc_timer_sva (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .TMR0_IRQ_O(TMR0_IRQ_O), .TMR1_IRQ_O(TMR1_IRQ_O));
